// ---- inc/isc_pkg.sv ----
// constants, register map and state codes of the i2c slave status/control block
// assumes an apb master on the register side and an external i2c master on the bus
//
// How it works
// - start condition sets start-seen flag
// - stop flag set in stop, start clears
// - direction flag takes matched address r/w bit
// - direction cleared by start, stop, nack
// - address/data flag updates at eighth fall
// - write direction byte sets full, read clears
// - full flag never written directly
// - read direction buffer write sets full
// - ninth rise samples data into ack
// - start condition clears ack flag
// - buffer write allowed only when stretched read
// - write collision stays until software clears
// - byte into full buffer flags overflow
// - overflow stays until software clears it
// - control bit 5 holds module reset
// - control bit 4 enables read stretching
// - control bit 3 enables write stretching
// - control bit 2 releases clock line
// - control bit 1 selects pad slew
// - control bit 0 enables the module
// - ninth fall raises irq, may stretch
// - only matching seven-bit address proceeds
// - no read stretch sends preload immediately

package isc_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_ADDR = 8'he3; // own address
  localparam logic [7:0] IDX_BUF = 8'he4; // shift data
  localparam logic [7:0] IDX_CON = 8'he5; // control
  localparam logic [7:0] IDX_STAT = 8'he8; // status
  localparam logic [7:0] IDX_PRE = 8'he9; // transmit preload

  // ==========================================================
  // reset values
  localparam logic [7:0] CON_RST = 8'h10;
  localparam logic [7:0] STAT_RST = 8'h44;

  // ==========================================================
  // status bit positions
  localparam int B_STA = 7;
  localparam int B_STO = 6;
  localparam int B_RW = 5;
  localparam int B_AD = 4;
  localparam int B_BF = 3;
  localparam int B_ACK = 2;
  localparam int B_WCOL = 1;
  localparam int B_ROV = 0;

  // ==========================================================
  // control bit positions
  localparam int C_RST = 5;
  localparam int C_RDS = 4;
  localparam int C_WRS = 3;
  localparam int C_REL = 2;
  localparam int C_SLEW = 1;
  localparam int C_EN = 0;

  // ==========================================================
  // bit counter values (counts rising bus clock edges)
  localparam logic [3:0] CNT_BYTE = 4'h8; // after eighth rise
  localparam logic [3:0] CNT_ACK = 4'h9; // after ninth rise

  // ==========================================================
  // byte engine states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_RX = 5'h04,
    ST_TX = 5'h08,
    ST_SKIP = 5'h10
  } isc_state_e;

endpackage

// ---- hdl/isc_sync.sv ----
// bus line synchroniser and start/stop/edge detector
// assumes raw pin levels from outside the clock domain
`timescale 1ns/1ps

module isc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw bus lines
  input wire logic scl_pin,
  input wire logic sda_pin,
  // synchronised levels and events
  output logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_ev,
  output logic stop_ev
);

  // [0] first stage, [1] second stage, [2] history
  typedef struct packed {
    logic [2:0] scl;
    logic [2:0] sda;
  } isc_sync_s;

  isc_sync_s r_q;
  isc_sync_s d;

  // ==========================================================
  // shift chain
  always_comb begin
    d.scl = {r_q.scl[1:0], scl_pin};
    d.sda = {r_q.sda[1:0], sda_pin};
  end

  // idle bus is high, so reset to ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '1;
    end else begin
      r_q <= d;
    end
  end

  // ==========================================================
  // events use only second stage and history
  assign sda_s = r_q.sda[1];
  assign scl_rise = r_q.scl[1] & ~r_q.scl[2];
  assign scl_fall = ~r_q.scl[1] & r_q.scl[2];
  assign start_ev = r_q.scl[1] & r_q.scl[2] & ~r_q.sda[1] & r_q.sda[2];
  assign stop_ev = r_q.scl[1] & r_q.scl[2] & r_q.sda[1] & ~r_q.sda[2];

endmodule

// ---- hdl/isc_apb.sv ----
// apb slave front end: one wait state, registered answer
// assumes the main block decodes the index and supplies read data
`timescale 1ns/1ps

module isc_apb (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // apb answer
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // register side
  input wire logic [7:0] rdata,
  input wire logic hit,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] idx,
  output logic [7:0] wdata
);

  typedef struct packed {
    logic rdy;
    logic err;
    logic [7:0] dat;
  } isc_apb_s;

  isc_apb_s r_q;
  isc_apb_s d;
  logic commit; // access completes this edge

  // word aligned decode of the index
  assign idx = paddr[9:2];
  assign wdata = pwdata[7:0];
  assign commit = psel & penable & r_q.rdy;
  assign wr_stb = commit & pwrite;
  assign rd_stb = commit & ~pwrite;

  // ==========================================================
  // ready rises one cycle into access, drops after commit
  always_comb begin
    d = r_q;
    if (commit) begin
      d.rdy = 1'b0;
      d.err = 1'b0;
    end else if (psel && penable) begin
      d.rdy = 1'b1;
      d.err = ~hit; // unmapped or misaligned
      d.dat = hit ? rdata : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '0;
    end else begin
      r_q <= d;
    end
  end

  assign pready = r_q.rdy;
  assign pslverr = r_q.err;
  assign prdata = {24'h000000, r_q.dat};

endmodule

// ---- hdl/isc_top.sv ----
// i2c slave status and control block, top level
// assumes open-drain pads outside and an apb master on REF_CLK
`timescale 1ns/1ps

module isc_top (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // i2c clock line, open drain
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  // i2c data line, open drain
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // pad and cpu side signals
  output logic SLEW_CONTROL_OFF,
  output logic BYTE_IRQ
);

  // ==========================================================
  // state of the block
  typedef struct packed {
    isc_pkg::isc_state_e st; // byte engine
    logic [3:0] cnt; // rising edges in byte
    logic [7:0] shift_in; // receive shifter
    logic [7:0] shift_data_reg; // cpu data buffer
    logic [7:0] tx_preload_reg; // next byte to send
    logic [6:0] own_address_reg; // seven-bit address
    logic [7:0] con; // control register
    logic start_flag;
    logic stop_flag;
    logic dir_read; // master reads
    logic data_flag; // last byte was data
    logic buffer_full_flag;
    logic ack_flag; // 1 means nack
    logic write_collision_flag;
    logic rx_overflow_flag;
    logic acking; // driving ack low
    logic scl_hi; // link clock level as last seen
    logic irq; // byte interrupt pulse
    logic scl_oe;
    logic sda_oe;
  } isc_regs_s;

  // reset image of the whole block
  function automatic isc_regs_s rst_val();
    isc_regs_s v;
    v = '0;
    v.st = isc_pkg::ST_IDLE;
    v.con = isc_pkg::CON_RST;
    v.stop_flag = isc_pkg::STAT_RST[isc_pkg::B_STO];
    v.ack_flag = isc_pkg::STAT_RST[isc_pkg::B_ACK];
    return v;
  endfunction

  localparam isc_regs_s RST_S = rst_val();

  // ==========================================================
  // reset release through two flip-flops
  logic [1:0] rst_q; // reset synchroniser
  logic rst_n; // released copy

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_n = rst_q[1];

  // ==========================================================
  // sub blocks
  logic sda_s; // synchronised data line
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic wr_stb; // write commits this edge
  logic rd_stb; // read commits this edge
  logic [7:0] idx; // register index
  logic [7:0] wdata; // write data low byte
  logic [7:0] rdata; // read data mux
  logic hit; // index is mapped

  isc_sync u_sync (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .scl_pin(SCL_I),
    .sda_pin(SDA_I),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_ev(start_ev),
    .stop_ev(stop_ev)
  );

  isc_apb u_apb (
    .clk(REF_CLK),
    .rst_n(rst_n),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .pready(PREADY),
    .prdata(PRDATA),
    .pslverr(PSLVERR),
    .rdata(rdata),
    .hit(hit),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .idx(idx),
    .wdata(wdata)
  );

  isc_regs_s r_q;
  isc_regs_s d;

  // ==========================================================
  // status byte, used by read mux and nowhere else twice
  function automatic logic [7:0] status_of(isc_regs_s s);
    return {s.start_flag, s.stop_flag, s.dir_read, s.data_flag,
            s.buffer_full_flag, s.ack_flag, s.write_collision_flag,
            s.rx_overflow_flag};
  endfunction

  // read data and map check
  always_comb begin
    hit = 1'b1;
    if (PADDR[1:0] != 2'b00 || PADDR[11:10] != 2'b00) begin
      hit = 1'b0;
      rdata = 8'h00;
    end else if (idx == isc_pkg::IDX_ADDR) begin
      rdata = {r_q.own_address_reg, 1'b0};
    end else if (idx == isc_pkg::IDX_BUF) begin
      rdata = r_q.shift_data_reg;
    end else if (idx == isc_pkg::IDX_CON) begin
      rdata = r_q.con;
    end else if (idx == isc_pkg::IDX_STAT) begin
      rdata = status_of(r_q);
    end else if (idx == isc_pkg::IDX_PRE) begin
      rdata = r_q.tx_preload_reg;
    end else begin
      hit = 1'b0;
      rdata = 8'h00;
    end
  end

  // ==========================================================
  // bus event qualifiers
  logic run; // enabled and out of soft reset
  logic fall8; // falling edge of eighth clock
  logic rise9; // rising edge of ninth clock
  logic fall9; // falling edge of ninth clock
  logic wr_buf; // cpu writes data buffer
  logic buf_ok; // buffer write permitted
  logic store_rx; // received byte goes to buffer
  logic stretch; // hold clock after ninth fall
  logic matched; // own address on the bus

  assign run = r_q.con[isc_pkg::C_EN] & ~r_q.con[isc_pkg::C_RST];
  assign fall8 = run & scl_fall & (r_q.cnt == isc_pkg::CNT_BYTE);
  assign rise9 = run & scl_rise & (r_q.cnt == isc_pkg::CNT_BYTE);
  assign fall9 = run & scl_fall & (r_q.cnt == isc_pkg::CNT_ACK);
  assign wr_buf = wr_stb & (idx == isc_pkg::IDX_BUF);
  assign buf_ok = r_q.dir_read & r_q.con[isc_pkg::C_RDS] & ~r_q.con[isc_pkg::C_REL];
  assign matched = (r_q.shift_in[7:1] == r_q.own_address_reg);
  assign store_rx = fall8 & ~start_ev & ~stop_ev &
    ((r_q.st == isc_pkg::ST_RX) | ((r_q.st == isc_pkg::ST_ADDR) & matched & ~r_q.shift_in[0]));
  assign stretch = r_q.dir_read ? r_q.con[isc_pkg::C_RDS] : r_q.con[isc_pkg::C_WRS];

  // ==========================================================
  // next state: cpu accesses first, bus events after so set wins
  always_comb begin
    d = r_q;
    d.irq = 1'b0;
    d.scl_hi = scl_rise | (r_q.scl_hi & ~scl_fall); // tracks the synchronised clock
    // cpu writes
    if (wr_stb) begin
      if (idx == isc_pkg::IDX_CON) begin
        d.con = {2'b00, wdata[5:0]};
      end else if (idx == isc_pkg::IDX_ADDR) begin
        d.own_address_reg = wdata[7:1];
      end else if (idx == isc_pkg::IDX_PRE) begin
        d.tx_preload_reg = wdata;
      end else if (idx == isc_pkg::IDX_STAT) begin
        // sticky flags: writing 0 clears, 1 keeps
        d.write_collision_flag = r_q.write_collision_flag & wdata[isc_pkg::B_WCOL];
        d.rx_overflow_flag = r_q.rx_overflow_flag & wdata[isc_pkg::B_ROV];
      end else if (idx == isc_pkg::IDX_BUF) begin
        if (buf_ok) begin
          d.shift_data_reg = wdata;
          d.buffer_full_flag = 1'b1;
        end else begin
          d.write_collision_flag = 1'b1;
        end
      end
    end
    // reading the buffer empties it
    if (rd_stb && idx == isc_pkg::IDX_BUF) begin
      d.buffer_full_flag = 1'b0;
    end
    // bus side
    if (run) begin
      if (start_ev) begin
        // start: also a repeated start mid byte
        d.st = isc_pkg::ST_ADDR;
        d.cnt = 4'h0;
        d.start_flag = 1'b1;
        d.stop_flag = 1'b0;
        d.dir_read = 1'b0;
        d.ack_flag = 1'b0;
        d.acking = 1'b0;
      end else if (stop_ev) begin
        // stop: bus idle again
        d.st = isc_pkg::ST_IDLE;
        d.stop_flag = 1'b1;
        d.start_flag = 1'b0;
        d.dir_read = 1'b0;
        d.acking = 1'b0;
      end else if (r_q.st != isc_pkg::ST_IDLE) begin
        // data bits sampled on rising edges, msb first
        if (scl_rise && r_q.cnt < isc_pkg::CNT_BYTE) begin
          d.shift_in = {r_q.shift_in[6:0], sda_s};
        end
        if (scl_rise && r_q.cnt < isc_pkg::CNT_ACK) begin
          d.cnt = r_q.cnt + 4'h1;
        end
        if (rise9 && r_q.st != isc_pkg::ST_SKIP) begin
          d.ack_flag = sda_s;
          if (sda_s && r_q.st == isc_pkg::ST_TX) begin
            d.dir_read = 1'b0;
            d.st = isc_pkg::ST_SKIP;
          end
        end
        case (r_q.st)
          isc_pkg::ST_ADDR: begin
            if (fall8) begin
              if (matched) begin
                d.data_flag = 1'b0;
                d.dir_read = r_q.shift_in[0];
                d.acking = 1'b1;
              end else begin
                d.st = isc_pkg::ST_SKIP;
              end
            end
            if (fall9) begin
              d.st = r_q.dir_read ? isc_pkg::ST_TX : isc_pkg::ST_RX;
            end
          end
          isc_pkg::ST_RX: begin
            if (fall8) begin
              d.data_flag = 1'b1;
              d.acking = 1'b1;
            end
          end
          isc_pkg::ST_TX: begin
            if (fall8) begin
              d.data_flag = 1'b1;
              d.buffer_full_flag = 1'b0;
            end
          end
          default: begin
            // idle and skip: wait for start or stop
          end
        endcase
        // end of byte: interrupt, stretch or preload
        if (fall9 && (r_q.st == isc_pkg::ST_ADDR || r_q.st == isc_pkg::ST_RX ||
            r_q.st == isc_pkg::ST_TX)) begin
          d.cnt = 4'h0;
          d.acking = 1'b0;
          d.irq = 1'b1;
          if (stretch) begin
            d.con[isc_pkg::C_REL] = 1'b0;
          end else if (r_q.dir_read) begin
            d.shift_data_reg = r_q.tx_preload_reg;
            d.buffer_full_flag = 1'b1;
          end
        end else if (fall9) begin
          d.cnt = 4'h0;
        end
      end
    end
    // receive into buffer, or overflow when still full
    if (store_rx) begin
      if (r_q.buffer_full_flag) begin
        d.rx_overflow_flag = 1'b1;
      end else begin
        d.shift_data_reg = r_q.shift_in;
        d.buffer_full_flag = 1'b1;
      end
    end
    // soft reset holds everything but the control register
    if (r_q.con[isc_pkg::C_RST]) begin
      d = '{default: '0, st: isc_pkg::ST_IDLE, con: d.con,
            stop_flag: RST_S.stop_flag, ack_flag: RST_S.ack_flag};
    end
    // pin drives follow the next state
    d.scl_oe = d.con[isc_pkg::C_EN] & ~d.con[isc_pkg::C_RST] &
      ~d.con[isc_pkg::C_REL];
    // count steps on the rise, so keep the old bit until the clock falls:
    // a data change while the clock is high would look like start or stop
    d.sda_oe = d.con[isc_pkg::C_EN] & ~d.con[isc_pkg::C_RST] &
      (d.acking | ((d.st == isc_pkg::ST_TX) &
      ((d.cnt - 4'(d.scl_hi)) < isc_pkg::CNT_BYTE) &
      ~d.shift_data_reg[3'(4'h7 - d.cnt + 4'(d.scl_hi))]));
  end

  // ==========================================================
  // single register stage
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= RST_S;
    end else begin
      r_q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign SCL_O = 1'b0; // open drain only pulls low
  assign SDA_O = 1'b0;
  assign SCL_OE = r_q.scl_oe;
  assign SDA_OE = r_q.sda_oe;
  assign SLEW_CONTROL_OFF = r_q.con[isc_pkg::C_SLEW];
  assign BYTE_IRQ = r_q.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!rst_n);

  sequence s_nack_read;
    rise9 && sda_s && r_q.st == isc_pkg::ST_TX && !start_ev && !stop_ev;
  endsequence

  a_start_flags: assert property (run && start_ev |=>
    r_q.start_flag && !r_q.stop_flag && !r_q.ack_flag && !r_q.dir_read)
    else $error("start did not set flags");
  a_stop_flag: assert property (run && stop_ev && !r_q.con[isc_pkg::C_RST] |=>
    r_q.stop_flag && !r_q.start_flag[*2])
    else $error("stop flag wrong");
  a_nack_dir: assert property (s_nack_read |=>
    !r_q.dir_read && r_q.ack_flag && r_q.st == isc_pkg::ST_SKIP)
    else $error("nack did not clear direction");
  a_ack_sample: assert property (rise9 && !start_ev && !stop_ev &&
    r_q.st != isc_pkg::ST_SKIP |=> r_q.ack_flag == $past(sda_s))
    else $error("ack not sampled");
  a_bad_write: assert property (wr_buf && !buf_ok && !store_rx && !fall9 |=>
    r_q.write_collision_flag && $stable(r_q.shift_data_reg))
    else $error("collision not flagged");
  a_wcol_keep: assert property (r_q.write_collision_flag &&
    !(wr_stb && idx == isc_pkg::IDX_STAT) && !r_q.con[isc_pkg::C_RST] |=>
    r_q.write_collision_flag)
    else $error("collision flag lost");
  a_ovf_keep: assert property (store_rx && r_q.buffer_full_flag |=>
    r_q.rx_overflow_flag && $stable(r_q.shift_data_reg))
    else $error("overflow not handled");
  a_rx_full: assert property (store_rx && !r_q.buffer_full_flag |=>
    r_q.buffer_full_flag && r_q.shift_data_reg == $past(r_q.shift_in))
    else $error("received byte not stored");
  a_irq_stretch: assert property (fall9 && stretch && r_q.st != isc_pkg::ST_SKIP &&
    r_q.st != isc_pkg::ST_IDLE && !start_ev && !stop_ev |=>
    BYTE_IRQ && !r_q.con[isc_pkg::C_REL] ##1 !BYTE_IRQ)
    else $error("stretch after ninth clock wrong");
  a_disabled: assert property (!r_q.con[isc_pkg::C_EN] |-> !SCL_OE && !SDA_OE)
    else $error("disabled block drives bus");

endmodule

// ---- tb/isc_i2c_host.sv ----
// i2c bus master model on an open-drain clock and data line
// assumes the bench resolves both lines with pull-ups
`timescale 1ns/1ps

module isc_i2c_host (
  // resolved bus levels
  input wire logic scl_w,
  input wire logic sda_w,
  // pull-down requests
  output logic scl_low,
  output logic sda_low
);
  // ==========================================================
  // line control, 400 ns clock period
  initial begin
    scl_low = 1'b0; // both lines released when idle
    sda_low = 1'b0;
  end

  // wait while the slave stretches the clock, bounded
  task automatic wait_high();
    int n;
    for (n = 0; n < 2000 && scl_w !== 1'b1; n++) #50;
  endtask

  // one clock pulse; data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    #100;
    scl_low = 1'b0;
    wait_high();
    #200;
    s = sda_w;
    scl_low = 1'b1;
    #100;
  endtask

  // data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    scl_low = 1'b0;
    #200;
    sda_low = 1'b1;
    #200;
    scl_low = 1'b1;
    #100;
  endtask

  // data rises while the clock is high
  task automatic stop();
    sda_low = 1'b1;
    #100;
    scl_low = 1'b0;
    wait_high();
    #200;
    sda_low = 1'b0;
    #300;
  endtask

  // eight bits msb first, then the acknowledge clock
  task automatic xfer(input logic [7:0] tx, input logic ackb, output logic [7:0] rx,
                      output logic ack);
    int i;
    for (i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ackb, ack);
  endtask
endmodule

// ---- tb/tb_isc_top.sv ----
// self-checking bench for the i2c slave status and control block
// assumes the host model on the bus and an apb master driven here
`timescale 1ns/1ps

module tb_isc_top;
  // ==========================================================
  // signals and register indices
  localparam logic [7:0] ST = isc_pkg::IDX_STAT;
  localparam logic [7:0] BF = isc_pkg::IDX_BUF;
  localparam logic [7:0] CN = isc_pkg::IDX_CON;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic pready, pslverr, scl_oe, sda_oe, scl_low, sda_low, slew_off, irq, ack;
  logic [31:0] prdata;
  logic [7:0] rx;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int irq_cnt = 0;
  wire scl_w = !(scl_oe === 1'b1 || scl_low); // wired-and with pull-up
  wire sda_w = !(sda_oe === 1'b1 || sda_low);

  isc_top dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .SCL_I(scl_w), .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda_w),
    .SDA_O(), .SDA_OE(sda_oe), .SLEW_CONTROL_OFF(slew_off), .BYTE_IRQ(irq));
  isc_i2c_host host (.scl_w(scl_w), .sda_w(sda_w), .scl_low(scl_low), .sda_low(sda_low));

  // ==========================================================
  // clock, interrupt pulse count, timeout
  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cycles == 40000) begin
      num_errors++;
      conclude();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata[7:0];
    err = pslverr;
    check("pready", 8'h01, {7'h00, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask

  // masked register read compare
  task automatic creg(input string what, input logic [7:0] idx, input logic [7:0] m,
                      input logic [7:0] exp);
    logic [7:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    check(what, exp, r & m);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] r;
    logic e;
    creg("control", CN, 8'hff, isc_pkg::CON_RST);
    creg("status", ST, 8'hff, isc_pkg::STAT_RST);
    apb(1'b0, 8'h10, 8'h00, r, e);
    check("unmapped", 8'h01, {7'h00, e});
    wreg(ST, 8'h00); // upper flags are read-only
    creg("status ro", ST, 8'hff, isc_pkg::STAT_RST);
  endtask

  task automatic t_write();
    wreg(isc_pkg::IDX_ADDR, 8'hb4); // own address 0x5a
    wreg(CN, 8'h17); // enabled, released, slew off
    host.start();
    check("slew", 8'h01, {7'h00, slew_off});
    creg("start", ST, 8'hc0, 8'h80);
    host.xfer(8'hb4, 1'b1, rx, ack);
    check("addr ack", 8'h00, {7'h00, ack});
    repeat (6) @(posedge ref_clk); // let the interrupt pulse pass
    check("irq", 8'h01, irq_cnt[7:0]);
    creg("addr byte", ST, 8'h3c, 8'h08);
    creg("buffer", BF, 8'hff, 8'hb4);
    creg("full clr", ST, 8'h08, 8'h00);
    host.xfer(8'h3c, 1'b1, rx, ack);
    creg("data byte", ST, 8'h19, 8'h18);
    host.xfer(8'hc3, 1'b1, rx, ack);
    creg("overflow", ST, 8'h09, 8'h09);
    creg("kept", BF, 8'hff, 8'h3c);
    wreg(BF, 8'h99); // write direction refuses cpu data
    creg("collision", ST, 8'h03, 8'h03);
    creg("unchanged", BF, 8'hff, 8'h3c);
    wreg(ST, 8'h00);
    creg("cleared", ST, 8'h03, 8'h00);
    host.stop();
    creg("stop", ST, 8'h70, 8'h50);
    host.start();
    host.xfer(8'h66, 1'b1, rx, ack);
    check("foreign", 8'h01, {7'h00, ack});
    repeat (6) @(posedge ref_clk); // a wrong pulse would have come by now
    check("no irq", 8'h03, irq_cnt[7:0]);
    host.stop();
  endtask

  task automatic t_read();
    wreg(CN, 8'h15); // read stretching, released
    host.start();
    host.xfer(8'hb5, 1'b1, rx, ack);
    repeat (4) @(posedge ref_clk);
    check("stretch", 8'h01, {7'h00, scl_oe});
    creg("dir read", ST, 8'h20, 8'h20);
    creg("rel clr", CN, 8'h04, 8'h00);
    wreg(BF, 8'ha5); // load before release
    creg("tx full", ST, 8'h0a, 8'h08);
    wreg(CN, 8'h15);
    repeat (3) @(posedge ref_clk);
    check("release", 8'h00, {7'h00, scl_oe});
    host.xfer(8'hff, 1'b1, rx, ack); // host ends with nack
    check("read data", 8'ha5, rx);
    creg("nack", ST, 8'h2c, 8'h04);
    host.stop();
    host.start();
    creg("ack at start", ST, 8'h04, 8'h00);
    wreg(CN, 8'h35);
    creg("soft reset", ST, 8'hff, isc_pkg::STAT_RST);
    wreg(CN, 8'h0d); // write stretching only
    wreg(isc_pkg::IDX_ADDR, 8'hb4); // soft reset cleared the own address
    host.stop();
    host.start();
    host.xfer(8'hb4, 1'b1, rx, ack);
    repeat (4) @(posedge ref_clk);
    check("wr stretch", 8'h01, {7'h00, scl_oe});
    creg("buf read", BF, 8'hff, 8'hb4);
    wreg(CN, 8'h0d);
    host.stop();
    wreg(CN, 8'h05); // no read stretching, slew control on
    check("slew on", 8'h00, {7'h00, slew_off});
    wreg(isc_pkg::IDX_PRE, 8'h5c);
    host.start();
    host.xfer(8'hb5, 1'b1, rx, ack);
    host.xfer(8'hff, 1'b1, rx, ack);
    check("preload", 8'h5c, rx);
    host.stop();
    wreg(CN, 8'h14); // module disabled
    host.start();
    host.xfer(8'hb4, 1'b1, rx, ack);
    check("disabled", 8'h01, {7'h00, ack, scl_oe, sda_oe} == 3'b100);
    host.stop();
  endtask

  // ==========================================================
  // verdict
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    t_reset();
    t_write();
    t_read();
    conclude();
  end
endmodule
